// [core/rspg_pkg.sv]
// Package of the sector password guard: field layout, reset values, command
// and state encodings, and the carrier structs for the RF and I2C ports.
// Assumes a single 100 MHz clock domain shared by every user of the package.
package rspg_pkg;
  // Geometry
  localparam int unsigned SECTORS     = 16;
  localparam int unsigned PWD_COUNT   = 3;
  localparam int unsigned PWD_W       = 32;
  // Guard byte field positions
  localparam int unsigned LOCK_BIT    = 0;
  localparam int unsigned PROT_LSB    = 1;
  localparam int unsigned LINK_LSB    = 3;
  localparam logic [7:0]  GUARD_MASK  = 8'h1f;
  // Reset values as delivered
  localparam logic [7:0]  GUARD_RST   = 8'h00;
  localparam logic [31:0] PWD_RST     = 32'h0000_0000;
  // Protection codes
  localparam logic [1:0]  PROT_WR_PWD = 2'h0;
  localparam logic [1:0]  PROT_OPEN   = 2'h1;
  localparam logic [1:0]  PROT_RW_PWD = 2'h2;
  localparam logic [1:0]  PROT_RD_PWD = 2'h3;
  localparam logic [1:0]  LINK_NONE   = 2'h0;
  // Password write cycle length, in clock cycles
  localparam int unsigned PROG_CYCLES = 4;

  typedef enum logic [1:0] {
    RSPG_OP_PWD_WR  = 2'b00,
    RSPG_OP_LOCK    = 2'b01,
    RSPG_OP_PRESENT = 2'b10,
    RSPG_OP_ACCESS  = 2'b11
  } rspg_op_t;

  typedef enum logic [1:0] {
    RSPG_PH_IDLE = 2'b00,
    RSPG_PH_PROG = 2'b01
  } rspg_state_t;

  // Contactless command; data[4:1] carries new lock settings
  typedef struct packed {
    rspg_op_t    op;
    logic [3:0]  sector;
    logic [1:0]  pwd_sel;
    logic        is_write;
    logic [31:0] data;
  } rspg_rf_cmd_t;

  typedef struct packed {
    logic       err;
    logic       rd_ok;
    logic       wr_ok;
    logic [7:0] guard;
  } rspg_rf_rsp_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  word;
    logic [3:0]  be;
    logic [31:0] wdata;
  } rspg_i2c_req_t;
endpackage

// [core/rspg_access_dec.sv]
// Access decoder: turns one guard byte and the session grant into read and
// write permission. Purely combinational; used for the addressed sector.
`timescale 1ns/1ns
module rspg_access_dec (
  // Sector state
  input  wire logic [7:0] guard_i,
  input  wire logic       presented_i,
  // Permissions
  output logic            rd_ok_o,
  output logic            wr_ok_o
);
  logic [1:0] prot;
  logic       pwd;

  // A sector with no link never sees the presented column
  assign prot = guard_i[rspg_pkg::PROT_LSB +: 2];
  assign pwd  = presented_i && (guard_i[rspg_pkg::LINK_LSB +: 2] != rspg_pkg::LINK_NONE);

  // Protection table
  always_comb begin
    rd_ok_o = 1'b1;
    wr_ok_o = 1'b1;
    if (guard_i[rspg_pkg::LOCK_BIT]) begin
      case (prot)
        rspg_pkg::PROT_WR_PWD: begin
          wr_ok_o = pwd;
        end
        rspg_pkg::PROT_OPEN: begin
          wr_ok_o = 1'b1;
        end
        rspg_pkg::PROT_RW_PWD: begin
          rd_ok_o = pwd;
          wr_ok_o = pwd;
        end
        default: begin
          rd_ok_o = pwd;
          wr_ok_o = 1'b0;
        end
      endcase
    end
  end
endmodule

// [core/rspg_pwd_bank.sv]
// Password bank: three stored passwords at blocks 1..3 plus a full-width
// comparator. Block 0 is not a password and never matches or stores.
`timescale 1ns/1ns
module rspg_pwd_bank #(
  parameter int unsigned PWD_W = rspg_pkg::PWD_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Store port
  input  wire logic             wr_en_i,
  input  wire logic [1:0]       wr_sel_i,
  input  wire logic [PWD_W-1:0] wr_data_i,
  // Compare port
  input  wire logic [1:0]       cmp_sel_i,
  input  wire logic [PWD_W-1:0] cmp_data_i,
  output logic                  match_o
);
  logic [PWD_W-1:0] pwd_q [1:rspg_pkg::PWD_COUNT];

  // Values are live as soon as stored; zero as delivered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 1; i <= rspg_pkg::PWD_COUNT; i++) begin
        pwd_q[i] <= PWD_W'(rspg_pkg::PWD_RST);
      end
    end else if (wr_en_i && wr_sel_i != 2'h0) begin
      pwd_q[wr_sel_i] <= wr_data_i;
    end
  end

  // Every bit must agree
  assign match_o = (cmp_sel_i != 2'h0) && (pwd_q[cmp_sel_i] == cmp_data_i);
endmodule

// [core/rspg_guard.sv]
// Sector password guard: sixteen guard bytes, session grants, the RF command
// engine and the I2C system-area port onto the guard bytes.
// Assumes one clock; the I2C password check and all framing live outside.
//
// Summary of operation
// - Guard byte: lock bit0, code 2:1, link 4:3
// - Unlocked open; locked follows protection code table
// - Link field picks none or password one-three
// - Passwords kept at system blocks one to three
// - Password write is only way to change
// - Stored password becomes active after write cycle
// - Password change needs prior valid presentation
// - Passwords are zero and active as delivered
// - Lock writes bits 4:1, forces lock bit
// - New lock settings apply immediately
// - Lock on locked sector answers error
// - Correct presentation grants linked sectors and block
// - Grants last until power loss or presentation
// - Wrong password revokes all granted rights
// - No password counts presented after power-up
// - I2C reads of guard bytes always allowed
// - I2C guard writes need I2C password first
// - I2C guard write resets sector RF access
// - Guard bytes read zero as delivered
// - Access replies also return the guard byte
// - Four guard bytes per word, sector n byte n
`timescale 1ns/1ns
module rspg_guard #(
  parameter int unsigned SECTORS     = rspg_pkg::SECTORS,
  parameter int unsigned PROG_CYCLES = rspg_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // Contactless command port
  input  wire logic                   rf_cmd_valid_i,
  input  wire rspg_pkg::rspg_rf_cmd_t rf_cmd_i,
  output logic                        rf_ready_o,
  output logic                        rf_rsp_valid_o,
  output rspg_pkg::rspg_rf_rsp_t      rf_rsp_o,
  // I2C system area port
  input  wire logic                   system_area_select_i,
  input  wire logic                   i2c_pwd_ok_i,
  input  wire rspg_pkg::rspg_i2c_req_t i2c_req_i,
  output logic                        i2c_ack_o,
  output logic                        i2c_err_o,
  output logic [31:0]                 i2c_rdata_o
);
  // Only the 16-sector map and a write counter that fits 8 bits are served
  if (SECTORS != 16) begin : g_bad_sectors
    $error("rspg_guard serves exactly 16 sectors");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES > 255) begin : g_bad_prog
    $error("PROG_CYCLES out of range");
  end

  logic [7:0]             guard_q [SECTORS];
  logic [3:0]             granted_q;
  rspg_pkg::rspg_state_t  state_q;
  logic [7:0]             prog_cnt_q;
  logic [1:0]             prog_sel_q;
  logic [31:0]            prog_data_q;
  logic [7:0]             sel_guard;
  logic                   sel_presented;
  logic                   acc_rd_ok;
  logic                   acc_wr_ok;
  logic                   pwd_match;
  logic                   take;
  logic                   lock_ok;
  logic                   pwd_wr_ok;
  logic                   prog_done;
  logic                   i2c_rd;
  logic                   i2c_wr;

  // Command is taken only between write cycles
  assign take      = rf_cmd_valid_i && state_q == rspg_pkg::RSPG_PH_IDLE;
  assign sel_guard = guard_q[rf_cmd_i.sector];
  assign sel_presented = granted_q[sel_guard[rspg_pkg::LINK_LSB +: 2]];
  assign lock_ok   = !sel_guard[rspg_pkg::LOCK_BIT];
  assign pwd_wr_ok = rf_cmd_i.pwd_sel != 2'h0 && granted_q[rf_cmd_i.pwd_sel];
  assign prog_done = state_q == rspg_pkg::RSPG_PH_PROG && prog_cnt_q == 8'h00;
  // Rule 18 is the master's job; without the select the port stays silent
  assign i2c_rd    = system_area_select_i && i2c_req_i.rd;
  assign i2c_wr    = system_area_select_i && i2c_req_i.wr && !i2c_req_i.rd;

  rspg_access_dec u_access_dec (
    .guard_i     (sel_guard),
    .presented_i (sel_presented),
    .rd_ok_o     (acc_rd_ok),
    .wr_ok_o     (acc_wr_ok)
  );

  rspg_pwd_bank #(
    .PWD_W (rspg_pkg::PWD_W)
  ) u_pwd_bank (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .wr_en_i    (prog_done),
    .wr_sel_i   (prog_sel_q),
    .wr_data_i  (prog_data_q),
    .cmp_sel_i  (rf_cmd_i.pwd_sel),
    .cmp_data_i (rf_cmd_i.data),
    .match_o    (pwd_match)
  );

  // Write cycle sequencer; the bank takes the value on the last cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q     <= rspg_pkg::RSPG_PH_IDLE;
      prog_cnt_q  <= 8'h00;
      prog_sel_q  <= 2'h0;
      prog_data_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        rspg_pkg::RSPG_PH_IDLE: begin
          if (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_PWD_WR && pwd_wr_ok) begin
            state_q     <= rspg_pkg::RSPG_PH_PROG;
            prog_cnt_q  <= 8'(PROG_CYCLES - 1);
            prog_sel_q  <= rf_cmd_i.pwd_sel;
            prog_data_q <= rf_cmd_i.data;
          end
        end
        rspg_pkg::RSPG_PH_PROG: begin
          if (prog_done) begin
            state_q <= rspg_pkg::RSPG_PH_IDLE;
          end else begin
            prog_cnt_q <= prog_cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= rspg_pkg::RSPG_PH_IDLE;
        end
      endcase
    end
  end

  // Session grants; bit 0 stays clear so unlinked sectors never gain rights
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      granted_q <= 4'h0;
    end else if (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_PRESENT) begin
      if (pwd_match) begin
        granted_q <= 4'h1 << rf_cmd_i.pwd_sel;
      end else begin
        granted_q <= 4'h0;
      end
    end
  end

  // Guard bytes; an I2C write in the same cycle lands after the RF lock
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int s = 0; s < SECTORS; s++) begin
        guard_q[s] <= rspg_pkg::GUARD_RST;
      end
    end else begin
      if (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_LOCK && lock_ok) begin
        guard_q[rf_cmd_i.sector] <= {3'h0, rf_cmd_i.data[4:1], 1'b1};
      end
      if (i2c_wr && i2c_pwd_ok_i) begin
        for (int b = 0; b < 4; b++) begin
          if (i2c_req_i.be[b]) begin
            guard_q[{i2c_req_i.word, 2'(b)}] <=
              i2c_req_i.wdata[8*b +: 8] & rspg_pkg::GUARD_MASK;
          end
        end
      end
    end
  end

  // RF answers: one cycle after take, or at the end of a write cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rf_rsp_valid_o <= 1'b0;
      rf_rsp_o       <= '0;
    end else begin
      rf_rsp_valid_o <= 1'b0;
      if (prog_done) begin
        rf_rsp_valid_o <= 1'b1;
        rf_rsp_o       <= '0;
      end else if (take) begin
        rf_rsp_valid_o <= !(rf_cmd_i.op == rspg_pkg::RSPG_OP_PWD_WR && pwd_wr_ok);
        rf_rsp_o       <= '0;
        case (rf_cmd_i.op)
          rspg_pkg::RSPG_OP_PWD_WR: begin
            rf_rsp_o.err <= !pwd_wr_ok;
          end
          rspg_pkg::RSPG_OP_LOCK: begin
            rf_rsp_o.err <= !lock_ok;
          end
          rspg_pkg::RSPG_OP_PRESENT: begin
            rf_rsp_o.err <= !pwd_match;
          end
          default: begin
            rf_rsp_o.rd_ok <= acc_rd_ok;
            rf_rsp_o.wr_ok <= acc_wr_ok;
            rf_rsp_o.guard <= sel_guard;
            rf_rsp_o.err   <= rf_cmd_i.is_write ? !acc_wr_ok : !acc_rd_ok;
          end
        endcase
      end
    end
  end

  // Ready drops for the whole write cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rf_ready_o <= 1'b1;
    end else begin
      rf_ready_o <= (state_q == rspg_pkg::RSPG_PH_IDLE) ? !(take &&
        rf_cmd_i.op == rspg_pkg::RSPG_OP_PWD_WR && pwd_wr_ok) : prog_done;
    end
  end

  // I2C answers one cycle after the request
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      i2c_ack_o   <= 1'b0;
      i2c_err_o   <= 1'b0;
      i2c_rdata_o <= 32'h0000_0000;
    end else begin
      i2c_ack_o <= i2c_rd || i2c_wr;
      i2c_err_o <= i2c_wr && !i2c_pwd_ok_i;
      if (i2c_rd) begin
        i2c_rdata_o <= {guard_q[{i2c_req_i.word, 2'h3}], guard_q[{i2c_req_i.word, 2'h2}],
                        guard_q[{i2c_req_i.word, 2'h1}], guard_q[{i2c_req_i.word, 2'h0}]};
      end
    end
  end

  // Checks
  property p_lock_sets;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_LOCK && lock_ok && !i2c_wr)
      |=> guard_q[$past(rf_cmd_i.sector)] == {3'h0, $past(rf_cmd_i.data[4:1]), 1'b1};
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock did not set guard");

  property p_lock_locked_err;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_LOCK && !lock_ok)
      |=> rf_rsp_valid_o && rf_rsp_o.err;
  endproperty
  a_lock_locked_err: assert property (p_lock_locked_err) else $error("relock accepted");

  property p_mismatch_revoke;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_PRESENT && !pwd_match) |=> granted_q == 4'h0;
  endproperty
  a_mismatch_revoke: assert property (p_mismatch_revoke) else $error("grant kept");

  property p_match_grant;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_PRESENT && pwd_match)
      |=> granted_q == (4'h1 << $past(rf_cmd_i.pwd_sel)) && rf_rsp_valid_o && !rf_rsp_o.err;
  endproperty
  a_match_grant: assert property (p_match_grant) else $error("grant missing");

  property p_pwd_wr_refused;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_PWD_WR && !pwd_wr_ok)
      |=> rf_rsp_valid_o && rf_rsp_o.err && state_q == rspg_pkg::RSPG_PH_IDLE;
  endproperty
  a_pwd_wr_refused: assert property (p_pwd_wr_refused) else $error("bad pwd write");

  property p_pwd_wr_cycle;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_PWD_WR && pwd_wr_ok)
      |=> !rf_ready_o ##[0:300] (rf_rsp_valid_o && !rf_rsp_o.err && rf_ready_o);
  endproperty
  a_pwd_wr_cycle: assert property (p_pwd_wr_cycle) else $error("write cycle hung");

  property p_unlocked_open;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_ACCESS && !sel_guard[rspg_pkg::LOCK_BIT])
      |=> rf_rsp_o.rd_ok && rf_rsp_o.wr_ok && rf_rsp_o.guard[7:5] == 3'h0;
  endproperty
  a_unlocked_open: assert property (p_unlocked_open) else $error("unlocked refused");

  property p_i2c_rd_ok;
    @(posedge clk_i) disable iff (!nrst_i)
    i2c_rd |=> i2c_ack_o && !i2c_err_o;
  endproperty
  a_i2c_rd_ok: assert property (p_i2c_rd_ok) else $error("i2c read refused");

  property p_i2c_wr_guard;
    @(posedge clk_i) disable iff (!nrst_i)
    (i2c_wr && !i2c_pwd_ok_i) |=> i2c_ack_o && i2c_err_o;
  endproperty
  a_i2c_wr_guard: assert property (p_i2c_wr_guard) else $error("i2c write unguarded");

  property p_guard_bits_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    take |-> sel_guard[7:5] == 3'h0;
  endproperty
  a_guard_bits_zero: assert property (p_guard_bits_zero) else $error("guard top bits set");

  property p_unlinked_no_grant;
    @(posedge clk_i) disable iff (!nrst_i)
    !granted_q[0];
  endproperty
  a_unlinked_no_grant: assert property (p_unlinked_no_grant) else $error("link 0 granted");

  property p_grant_hold;
    @(posedge clk_i) disable iff (!nrst_i)
    !(take && rf_cmd_i.op == rspg_pkg::RSPG_OP_PRESENT) |=> $stable(granted_q);
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant changed");

  property p_prog_done_rsp;
    @(posedge clk_i) disable iff (!nrst_i)
    prog_done |=> rf_ready_o && rf_rsp_valid_o && !rf_rsp_o.err;
  endproperty
  a_prog_done_rsp: assert property (p_prog_done_rsp) else $error("write end silent");

  property p_lock_rsp_ok;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_LOCK && lock_ok)
      |=> rf_rsp_valid_o && !rf_rsp_o.err;
  endproperty
  a_lock_rsp_ok: assert property (p_lock_rsp_ok) else $error("lock answer wrong");

  property p_access_guard;
    @(posedge clk_i) disable iff (!nrst_i)
    (take && rf_cmd_i.op == rspg_pkg::RSPG_OP_ACCESS)
      |=> rf_rsp_valid_o && rf_rsp_o.guard == $past(sel_guard);
  endproperty
  a_access_guard: assert property (p_access_guard) else $error("guard not returned");

  property p_i2c_wr_lane0;
    @(posedge clk_i) disable iff (!nrst_i)
    (i2c_wr && i2c_pwd_ok_i && i2c_req_i.be[0])
      |=> guard_q[{$past(i2c_req_i.word), 2'h0}] ==
          ($past(i2c_req_i.wdata[7:0]) & rspg_pkg::GUARD_MASK);
  endproperty
  a_i2c_wr_lane0: assert property (p_i2c_wr_lane0) else $error("i2c byte not stored");

  property p_i2c_rd_lane3;
    @(posedge clk_i) disable iff (!nrst_i)
    i2c_rd |=> i2c_rdata_o[31:24] == $past(guard_q[{i2c_req_i.word, 2'h3}]);
  endproperty
  a_i2c_rd_lane3: assert property (p_i2c_rd_lane3) else $error("i2c lane order");
endmodule

// [dv/rspg_host_model.sv]
// Host model: contactless reader and I2C master in front of the guard.
// Assumes one bench process calls its tasks, one transfer at a time.
`timescale 1ns/1ns
module rspg_host_model (
  // Clock
  input  wire logic                   clk_i,
  // RF side
  input  wire logic                   rf_ready_i,
  input  wire logic                   rf_rsp_valid_i,
  input  wire rspg_pkg::rspg_rf_rsp_t rf_rsp_i,
  output rspg_pkg::rspg_rf_cmd_t      rf_cmd_o,
  output logic                        rf_cmd_valid_o,
  // I2C side
  input  wire logic                   i2c_ack_i,
  input  wire logic                   i2c_err_i,
  input  wire logic [31:0]            i2c_rdata_i,
  output rspg_pkg::rspg_i2c_req_t     i2c_req_o,
  output logic                        sel_o,
  output logic                        pwd_ok_o
);
  // Idle bus at time zero
  initial begin
    rf_cmd_o = '0;
    rf_cmd_valid_o = 1'b0;
    i2c_req_o = '0;
    sel_o = 1'b0;
    pwd_ok_o = 1'b0;
  end

  // One RF command; held until taken, then waits for the answer
  task automatic rf(input rspg_pkg::rspg_op_t op, input logic [3:0] sec,
                    input logic [1:0] psel, input logic wr, input logic [31:0] data,
                    output rspg_pkg::rspg_rf_rsp_t rsp, output int cyc, output logic rdy1);
    @(negedge clk_i);
    rf_cmd_o = '{op: op, sector: sec, pwd_sel: psel, is_write: wr, data: data};
    rf_cmd_valid_o = 1'b1;
    // Ready is looked at while settled, half a cycle before the taking edge
    while (rf_ready_i !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    @(negedge clk_i);
    rf_cmd_valid_o = 1'b0;
    // Released lines never keep the old value
    rf_cmd_o = rspg_pkg::rspg_rf_cmd_t'(~rf_cmd_o);
    rdy1 = rf_ready_i;
    cyc = 1;
    while (rf_rsp_valid_i !== 1'b1 && cyc < 50) begin
      @(negedge clk_i);
      cyc++;
    end
    rsp = rf_rsp_i;
  endtask

  // One I2C system-area strobe; answer sampled one cycle later
  task automatic i2c(input logic rd, input logic wr, input logic sel, input logic pwd,
                     input logic [1:0] word, input logic [3:0] be, input logic [31:0] wd,
                     output logic ack, output logic err, output logic [31:0] rdata);
    @(negedge clk_i);
    sel_o = sel;
    pwd_ok_o = pwd;
    i2c_req_o = '{rd: rd, wr: wr, word: word, be: be, wdata: wd};
    @(negedge clk_i);
    i2c_req_o = '{rd: 1'b0, wr: 1'b0, word: ~word, be: ~be, wdata: ~wd};
    sel_o = 1'b0;
    ack = i2c_ack_i;
    err = i2c_err_i;
    rdata = i2c_rdata_i;
  endtask
endmodule

// [dv/rspg_guard_tb.sv]
// Bench for the sector password guard, driving it through the host model.
// Assumes a short password write cycle; all checks are self-contained.
`timescale 1ns/1ns
module rspg_guard_tb;
  localparam int unsigned PROG = 2;
  // Lock settings {link, code}, rights {rd, wr} before and after a grant
  localparam logic [3:0] LK [5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
  localparam logic [1:0] BEF [5] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h0};
  localparam logic [1:0] AFT [5] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h2};
  localparam logic [31:0] NEWPWD = 32'h1234_5678;

  logic                    clk_i;
  logic                    nrst_i;
  logic                    rf_cmd_valid;
  rspg_pkg::rspg_rf_cmd_t  rf_cmd;
  logic                    rf_ready;
  logic                    rf_rsp_valid;
  rspg_pkg::rspg_rf_rsp_t  rf_rsp;
  logic                    sel;
  logic                    pwd_ok;
  rspg_pkg::rspg_i2c_req_t i2c_req;
  logic                    i2c_ack;
  logic                    i2c_err;
  logic [31:0]             i2c_rdata;
  rspg_pkg::rspg_rf_rsp_t  rsp;
  logic                    rdy1;
  logic                    ack;
  logic                    err;
  logic [31:0]             rdv;
  int                      cyc;
  int                      cycles = 0;
  int                      err_count = 0;
  int                      n_tests = 0;

  rspg_guard #(.SECTORS(16), .PROG_CYCLES(PROG)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .rf_cmd_valid_i(rf_cmd_valid), .rf_cmd_i(rf_cmd),
    .rf_ready_o(rf_ready), .rf_rsp_valid_o(rf_rsp_valid), .rf_rsp_o(rf_rsp),
    .system_area_select_i(sel), .i2c_pwd_ok_i(pwd_ok), .i2c_req_i(i2c_req),
    .i2c_ack_o(i2c_ack), .i2c_err_o(i2c_err), .i2c_rdata_o(i2c_rdata));

  rspg_host_model u_host (
    .clk_i(clk_i), .rf_ready_i(rf_ready), .rf_rsp_valid_i(rf_rsp_valid),
    .rf_rsp_i(rf_rsp), .rf_cmd_o(rf_cmd), .rf_cmd_valid_o(rf_cmd_valid),
    .i2c_ack_i(i2c_ack), .i2c_err_i(i2c_err), .i2c_rdata_i(i2c_rdata),
    .i2c_req_o(i2c_req), .sel_o(sel), .pwd_ok_o(pwd_ok));

  // Free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Command whose outcomes of interest are the error flag and a one-cycle answer
  task automatic cmd(input rspg_pkg::rspg_op_t op, input logic [3:0] sec,
                     input logic [1:0] psel, input logic [31:0] data, input logic exp_err);
    u_host.rf(op, sec, psel, 1'b0, data, rsp, cyc, rdy1);
    // Answer must come one cycle after the take, not by running out of wait
    chk({cyc[30:0], rsp.err}, {31'h1, exp_err});
  endtask

  // Read query; err mirrors a missing read right
  task automatic query(input logic [3:0] sec, input logic [1:0] rw, input logic [7:0] g);
    u_host.rf(rspg_pkg::RSPG_OP_ACCESS, sec, 2'h0, 1'b0, 32'h0, rsp, cyc, rdy1);
    chk({cyc[9:0], 11'h0, rsp}, {10'h1, 11'h0, ~rw[1], rw, g});
  endtask

  task automatic t_reset;
    for (int w = 0; w < 4; w++) begin
      u_host.i2c(1'b1, 1'b0, 1'b1, 1'b0, 2'(w), 4'h0, 32'h0, ack, err, rdv);
      chk(rdv, 32'h0);
    end
    query(4'h7, 2'h3, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_lock;
    for (int s = 0; s < 5; s++) begin
      cmd(rspg_pkg::RSPG_OP_LOCK, 4'(s), 2'h0, {27'h7ffffff, LK[s], 1'b0}, 1'b0);
      query(4'(s), BEF[s], {3'h0, LK[s], 1'b1});
      // Write query: err follows the write right alone
      u_host.rf(rspg_pkg::RSPG_OP_ACCESS, 4'(s), 2'h0, 1'b1, 32'h0, rsp, cyc, rdy1);
      chk({31'h0, rsp.err}, {31'h0, ~BEF[s][0]});
    end
    cmd(rspg_pkg::RSPG_OP_LOCK, 4'h1, 2'h0, 32'h0, 1'b1);
    query(4'h1, BEF[1], 8'h09);
    $display("test lock done");
  endtask

  task automatic t_present;
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h1, 32'h0, 1'b0);
    for (int s = 0; s < 5; s++) begin
      query(4'(s), AFT[s], {3'h0, LK[s], 1'b1});
    end
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h1, 32'h0000_0001, 1'b1);
    for (int s = 0; s < 5; s++) begin
      query(4'(s), BEF[s], {3'h0, LK[s], 1'b1});
    end
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h1, 32'h0, 1'b0);
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h2, 32'h0, 1'b0);
    query(4'h3, BEF[3], 8'h0d);
    $display("test present done");
  endtask

  task automatic t_pwd;
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h1, 32'h0, 1'b0);
    u_host.rf(rspg_pkg::RSPG_OP_PWD_WR, 4'h0, 2'h1, 1'b1, NEWPWD, rsp, cyc, rdy1);
    chk({31'h0, rsp.err}, 32'h0);
    chk({31'h0, rdy1}, 32'h0);
    chk(32'(cyc), PROG + 1);
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h1, 32'h0, 1'b1);
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h1, NEWPWD, 1'b0);
    cmd(rspg_pkg::RSPG_OP_PWD_WR, 4'h0, 2'h3, 32'hcafe_0001, 1'b1);
    cmd(rspg_pkg::RSPG_OP_PWD_WR, 4'h0, 2'h0, 32'hcafe_0001, 1'b1);
    cmd(rspg_pkg::RSPG_OP_PRESENT, 4'h0, 2'h3, 32'h0, 1'b0);
    $display("test password done");
  endtask

  task automatic t_i2c;
    u_host.i2c(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 4'h0, 32'h0, ack, err, rdv);
    chk(rdv, 32'h0d0b_0901);
    chk({30'h0, ack, err}, 32'h2);
    u_host.i2c(1'b0, 1'b1, 1'b1, 1'b0, 2'h1, 4'hf, 32'hffff_ffff, ack, err, rdv);
    chk({30'h0, ack, err}, 32'h3);
    u_host.i2c(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 4'h5, 32'h55ff_aa00, ack, err, rdv);
    chk({30'h0, ack, err}, 32'h2);
    u_host.i2c(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 4'h0, 32'h0, ack, err, rdv);
    chk({30'h0, ack, err}, 32'h0);
    u_host.i2c(1'b1, 1'b0, 1'b1, 1'b0, 2'h1, 4'h0, 32'h0, ack, err, rdv);
    chk(rdv, 32'h001f_0000);
    query(4'h4, 2'h3, 8'h00);
    $display("test i2c done");
  endtask

  // Main sequence
  initial begin
    nrst_i = 1'b0;
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_lock();
    t_present();
    t_pwd();
    t_i2c();
    end_sim();
  end
endmodule
